/* common/retimer_ctrl_pkg.sv */
// Constants and types for the retimer channel control block
// Summary of operation
// RULE1: Detected input energy powers the channel data path up, absence powers it down.
// RULE2: After reset the detector drives data-path power with no host action.
// RULE3: Host can force a channel disabled; the forced state beats the detector.
// RULE4: During lock acquisition the boost is chosen by scoring candidate settings.
// RULE5: After lock and adaptation boost is frozen until re-adapt or reacquisition.
// RULE6: Resetting clock recovery restarts acquisition and so re-adaptation.
// RULE7: Boost is four stage fields of two bits each, 256 combinations.
// RULE8: Adaptation searches only the 32 entries at channel offsets 0x40 to 0x5F.
// RULE9: Every table entry is host-writable.
// RULE10: Entry boost level is the sum of its four stage codes.
// RULE11: A host control switches stage four from linear to limiting.
// RULE12: Reset default mode is automatic adaptation of the equalizer only.
// RULE13: Host must program swing and de-emphasis itself.
// RULE14: Swing and de-emphasis are held per channel, independent of others.
// RULE15: All configuration reachable through one slave port, or EEPROM load.
// RULE16: Swing is a 3-bit field, bits 2:0 of offset 0x2d, 0 lowest, 7 highest.
// RULE17: Interrupt on signal loss after presence and lock loss after lock.
// RULE18: Entry byte holds stage one in bits 7:6, stage four in bits 1:0.
// RULE19: Search keeps the highest score, ties going to the lowest index.
// RULE20: Re-adapt acts only while locked and restarts at entry zero.
package retimer_ctrl_pkg;
   localparam int unsigned NUM_CH       = 4;
   localparam int unsigned TABLE_DEPTH  = 32;
   localparam int unsigned STAGE_W      = 2;
   localparam int unsigned NUM_STAGES   = 4;
   localparam int unsigned BOOST_W      = STAGE_W * NUM_STAGES;
   localparam int unsigned SCORE_W      = 8;
   localparam int unsigned SWING_W      = 3;
   localparam int unsigned DEEMPH_W     = 4;
   localparam int unsigned REG_ADDR_W   = 8;
   localparam logic [7:0]  TABLE_BASE   = 8'h40;
   localparam logic [7:0]  TABLE_LAST   = 8'h5F;
   localparam logic [7:0]  SWING_REG    = 8'h2D;
   localparam int unsigned SWING_LSB    = 0;
   localparam logic [7:0]  DEEMPH_REG   = 8'h15;
   localparam logic [7:0]  CTRL_REG     = 8'h14;
   localparam int unsigned CTRL_FORCE   = 0;
   localparam int unsigned CTRL_LIMIT   = 1;
   localparam int unsigned CTRL_READAPT = 2;
   localparam logic [7:0]  ENTRY_RESET  = 8'h00;
   localparam logic [SWING_W-1:0]  SWING_RESET  = 3'h0;
   localparam logic [DEEMPH_W-1:0] DEEMPH_RESET = 4'h0;
   typedef enum logic [1:0] {ADAPT_IDLE, ADAPT_APPLY, ADAPT_SCORE, ADAPT_FROZEN} adapt_state_e;
endpackage

/* design/boost_search.sv */
// Table search engine: steps candidates and keeps the best merit score
`timescale 1ns/1ps
module boost_search #(
   parameter int unsigned DEPTH   = retimer_ctrl_pkg::TABLE_DEPTH,
   parameter int unsigned SCORE_W = retimer_ctrl_pkg::SCORE_W
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Control
   input  wire logic                     start,
   input  wire logic                     abort,
   input  wire logic                     score_valid,
   input  wire logic [SCORE_W-1:0]       adapt_merit_score,
   // Results
   output logic [$clog2(DEPTH)-1:0]      cand_idx,
   output logic [$clog2(DEPTH)-1:0]      best_idx,
   output logic                          busy,
   output logic                          done
);
   localparam int unsigned IW = $clog2(DEPTH);
   localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);

   logic [IW-1:0]      cand_q, cand_d, best_q, best_d;
   logic [SCORE_W-1:0] bscore_q, bscore_d;
   logic               busy_q, busy_d, done_q, done_d;
   wire                better = (cand_q == '0) || (adapt_merit_score > bscore_q); // RULE19

   // Strict compare keeps earlier index on ties
   always_comb begin
      cand_d   = cand_q;
      best_d   = best_q;
      bscore_d = bscore_q;
      busy_d   = busy_q;
      done_d   = 1'b0;
      if (abort) begin
         busy_d = 1'b0;
      end else if (start) begin
         cand_d = '0; // RULE20
         busy_d = 1'b1;
      end else if (busy_q && score_valid) begin
         if (better) begin
            best_d   = cand_q;
            bscore_d = adapt_merit_score;
         end
         if (cand_q == LAST) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end else begin
            cand_d = cand_q + IW'(1);
         end
      end
   end

   // Search registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cand_q   <= '0;
         best_q   <= '0;
         bscore_q <= '0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         cand_q   <= cand_d;
         best_q   <= best_d;
         bscore_q <= bscore_d;
         busy_q   <= busy_d;
         done_q   <= done_d;
      end
   end

   assign cand_idx = cand_q;
   assign best_idx = best_q;
   assign busy     = busy_q;
   assign done     = done_q;

   a_done_ends_busy: assert property (@(posedge clk) disable iff (rst) done |-> !busy) // RULE19
      else $error("search done while still busy");
endmodule

/* design/retimer_channel_eq_adapt_ctrl.sv */
// Per-channel signal gating, equalizer adaptation and driver settings
`timescale 1ns/1ps
module retimer_channel_eq_adapt_ctrl #(
   parameter int unsigned DEPTH   = retimer_ctrl_pkg::TABLE_DEPTH,
   parameter int unsigned SCORE_W = retimer_ctrl_pkg::SCORE_W
) (
   // Clock and reset
   input  wire logic                                    clk,
   input  wire logic                                    rst,
   // Register write port from the slave interface
   input  wire logic                                    reg_wr,
   input  wire logic [retimer_ctrl_pkg::REG_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                              reg_wdata,
   // Analog status, asynchronous to clk
   input  wire logic                                    sig_detect,
   input  wire logic                                    cdr_locked,
   input  wire logic                                    cdr_reset,
   // Merit scorer
   input  wire logic                                    score_valid,
   input  wire logic [SCORE_W-1:0]                      adapt_merit_score,
   // Data path controls
   output logic                                         datapath_en,
   output logic [retimer_ctrl_pkg::BOOST_W-1:0]         boost_code,
   output logic [4:0]                                   boost_level,
   output logic                                         stage4_limit,
   output logic [retimer_ctrl_pkg::SWING_W-1:0]         output_swing_setting,
   output logic [retimer_ctrl_pkg::DEEMPH_W-1:0]        deemph_setting,
   output logic                                         adapt_busy,
   output logic                                         adapt_frozen,
   // Interrupt, active low open drain
   output logic                                         int_o,
   output logic                                         int_oe,
   output logic                                         sig_lost_q,
   output logic                                         lock_lost_q
);
   localparam int unsigned IW = $clog2(DEPTH);
   localparam int unsigned BW = retimer_ctrl_pkg::BOOST_W;

   // Sum of the four 2-bit stage codes, stage one in the top bits
   function automatic logic [4:0] level_of(input logic [BW-1:0] e);
      level_of = 5'({3'h0, e[7:6]}) + 5'({3'h0, e[5:4]}) + 5'({3'h0, e[3:2]}) + 5'({3'h0, e[1:0]}); // RULE10 RULE18
   endfunction

   // Two-flop synchronisers for analog status
   logic [2:0] sync1_q, sync2_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {cdr_reset, cdr_locked, sig_detect};
         sync2_q <= sync1_q;
      end
   end
   wire sd_s  = sync2_q[0];
   wire lk_s  = sync2_q[1];
   wire crs_s = sync2_q[2];

   // Address decode
   wire wr_table  = reg_wr && (reg_addr >= retimer_ctrl_pkg::TABLE_BASE)
                    && (reg_addr <= retimer_ctrl_pkg::TABLE_LAST);      // RULE8 RULE9 RULE15
   wire wr_swing  = reg_wr && (reg_addr == retimer_ctrl_pkg::SWING_REG);  // RULE16
   wire wr_deemph = reg_wr && (reg_addr == retimer_ctrl_pkg::DEEMPH_REG);
   wire wr_ctrl   = reg_wr && (reg_addr == retimer_ctrl_pkg::CTRL_REG);
   wire [IW-1:0] wr_idx = IW'(reg_addr - retimer_ctrl_pkg::TABLE_BASE);

   // Candidate table, one byte per entry
   logic [BW-1:0] table_q [DEPTH];
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_tab
         always_ff @(posedge clk) begin
            if (rst) begin
               table_q[gi] <= retimer_ctrl_pkg::ENTRY_RESET;
            end else if (wr_table && (wr_idx == IW'(gi))) begin
               table_q[gi] <= reg_wdata; // RULE9 RULE18
            end
         end
      end
   endgenerate

   // Channel settings; this block is one channel so writes touch nothing else
   logic                 force_off_q, limit_q;
   logic [2:0]           swing_q;
   logic [3:0]           deemph_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         force_off_q <= 1'b0;                          // RULE2 RULE12
         limit_q     <= 1'b0;
         swing_q     <= retimer_ctrl_pkg::SWING_RESET;
         deemph_q    <= retimer_ctrl_pkg::DEEMPH_RESET;
      end else begin
         if (wr_ctrl) begin
            force_off_q <= reg_wdata[retimer_ctrl_pkg::CTRL_FORCE]; // RULE3
            limit_q     <= reg_wdata[retimer_ctrl_pkg::CTRL_LIMIT]; // RULE11
         end
         if (wr_swing) begin
            swing_q <= reg_wdata[retimer_ctrl_pkg::SWING_LSB +: retimer_ctrl_pkg::SWING_W]; // RULE16 RULE14
         end
         if (wr_deemph) begin
            deemph_q <= reg_wdata[retimer_ctrl_pkg::DEEMPH_W-1:0]; // RULE14 RULE13
         end
      end
   end
   wire readapt_cmd = wr_ctrl && reg_wdata[retimer_ctrl_pkg::CTRL_READAPT];

   // Data path power: detector unless host forces it off
   logic en_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= sd_s && !force_off_q; // RULE1 RULE3
      end
   end

   // Adaptation sequencing
   retimer_ctrl_pkg::adapt_state_e st_q, st_d;
   logic          lk_prev_q;
   logic [BW-1:0] boost_q, boost_d;
   wire           acq_entry = crs_s || (lk_prev_q && !lk_s) || !en_q; // RULE6 RULE5
   wire           do_readapt = readapt_cmd && lk_s;                   // RULE20
   logic          s_start, s_done, s_busy;
   logic [IW-1:0] cand_idx, best_idx;

   // Start on acquisition entry or honoured re-adapt
   always_comb begin
      st_d    = st_q;
      boost_d = boost_q;
      s_start = 1'b0;
      case (st_q)
         retimer_ctrl_pkg::ADAPT_IDLE: begin
            if (en_q && !crs_s && !lk_s) begin
               s_start = 1'b1; // RULE4
               st_d    = retimer_ctrl_pkg::ADAPT_SCORE;
            end
         end
         retimer_ctrl_pkg::ADAPT_SCORE: begin
            boost_d = table_q[cand_idx]; // RULE8
            if (s_done) begin
               st_d = retimer_ctrl_pkg::ADAPT_APPLY;
            end
         end
         retimer_ctrl_pkg::ADAPT_APPLY: begin
            boost_d = table_q[best_idx]; // RULE19
            if (lk_s) begin
               st_d = retimer_ctrl_pkg::ADAPT_FROZEN;
            end
         end
         retimer_ctrl_pkg::ADAPT_FROZEN: begin
            if (do_readapt) begin
               s_start = 1'b1; // RULE20
               st_d    = retimer_ctrl_pkg::ADAPT_SCORE;
            end
         end
         default: st_d = retimer_ctrl_pkg::ADAPT_IDLE;
      endcase
      if (acq_entry && !(st_q == retimer_ctrl_pkg::ADAPT_IDLE)) begin
         st_d = retimer_ctrl_pkg::ADAPT_IDLE; // RULE6
      end
   end

   // Adaptation state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q      <= retimer_ctrl_pkg::ADAPT_IDLE;
         boost_q   <= retimer_ctrl_pkg::ENTRY_RESET;
         lk_prev_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         boost_q   <= boost_d;
         lk_prev_q <= lk_s;
      end
   end

   boost_search #(.DEPTH(DEPTH), .SCORE_W(SCORE_W)) u_search (
      .clk               (clk),
      .rst               (rst),
      .start             (s_start),
      .abort             (acq_entry),
      .score_valid       (score_valid),
      .adapt_merit_score (adapt_merit_score),
      .cand_idx          (cand_idx),
      .best_idx          (best_idx),
      .busy              (s_busy),
      .done              (s_done)
   );

   // Sticky causes; set wins over clear, cleared by re-adapt command
   logic sd_prev_q, sl_q, ll_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         sd_prev_q <= 1'b0;
         sl_q      <= 1'b0;
         ll_q      <= 1'b0;
      end else begin
         sd_prev_q <= sd_s;
         sl_q      <= (sd_prev_q && !sd_s) || (sl_q && !readapt_cmd); // RULE17
         ll_q      <= (lk_prev_q && !lk_s) || (ll_q && !readapt_cmd); // RULE17
      end
   end

   assign datapath_en          = en_q;
   assign boost_code           = boost_q;              // RULE7
   assign boost_level          = level_of(boost_q);
   assign stage4_limit         = limit_q;
   assign output_swing_setting = swing_q;
   assign deemph_setting       = deemph_q;
   assign adapt_busy           = s_busy;
   assign adapt_frozen         = (st_q == retimer_ctrl_pkg::ADAPT_FROZEN);
   assign sig_lost_q           = sl_q;
   assign lock_lost_q          = ll_q;
   assign int_o                = 1'b0;
   assign int_oe               = sl_q || ll_q;  // Pulls line low while a cause is pending

   // Named steps of adaptation and of the status edges
   // Each adaptation step excludes an abort in the same cycle, since abort beats start in the search engine
   sequence s_lock_fall;
      lk_prev_q && !lk_s;
   endsequence
   sequence s_sig_fall;
      sd_prev_q && !sd_s;
   endsequence
   sequence s_idle_go;
      (st_q == retimer_ctrl_pkg::ADAPT_IDLE) && en_q && !crs_s && !lk_s && !lk_prev_q;
   endsequence
   sequence s_lock_seen;
      (st_q == retimer_ctrl_pkg::ADAPT_APPLY) && lk_s && !acq_entry;
   endsequence
   sequence s_readapt_go;
      adapt_frozen && readapt_cmd && lk_s && !acq_entry;
   endsequence

   // Frozen boost holds steady; path power follows detector and force
   a_boost_frozen: assert property (@(posedge clk) disable iff (rst) // RULE5
      (adapt_frozen && $past(adapt_frozen)) |-> $stable(boost_code))
      else $error("boost changed while frozen");
   a_force_off: assert property (@(posedge clk) disable iff (rst) // RULE3
      force_off_q |=> !datapath_en)
      else $error("forced channel still enabled");
   a_detect_power: assert property (@(posedge clk) disable iff (rst) // RULE1
      (sd_s && !force_off_q) |=> datapath_en)
      else $error("detected signal did not power path");
   a_detect_loss: assert property (@(posedge clk) disable iff (rst) // RULE1 RULE2
      !sd_s |=> !datapath_en)
      else $error("path powered with no signal");

   // Host settings land one cycle after the write strobe
   a_swing_write: assert property (@(posedge clk) disable iff (rst) // RULE16
      wr_swing |=> (output_swing_setting == $past(reg_wdata[2:0])))
      else $error("swing write lost");
   a_deemph_write: assert property (@(posedge clk) disable iff (rst) // RULE14
      wr_deemph |=> (deemph_setting == $past(reg_wdata[retimer_ctrl_pkg::DEEMPH_W-1:0])))
      else $error("de-emphasis write lost");
   a_limit_write: assert property (@(posedge clk) disable iff (rst) // RULE11
      wr_ctrl |=> (stage4_limit == $past(reg_wdata[retimer_ctrl_pkg::CTRL_LIMIT])))
      else $error("limiting control write lost");
   a_table_write: assert property (@(posedge clk) disable iff (rst) // RULE9 RULE18
      wr_table |=> (table_q[$past(wr_idx)] == $past(reg_wdata)))
      else $error("table entry write lost");

   // Interrupt causes latch one cycle after the synced falling edge
   // Set beats clear so an edge that meets a re-adapt write is never missed
   a_lock_lost_int: assert property (@(posedge clk) disable iff (rst) // RULE17
      s_lock_fall |=> (lock_lost_q && int_oe))
      else $error("lock loss not flagged");
   a_sig_lost_int: assert property (@(posedge clk) disable iff (rst) // RULE17
      s_sig_fall |=> (sig_lost_q && int_oe))
      else $error("signal loss not flagged");
   a_sig_lost_hold: assert property (@(posedge clk) disable iff (rst) // RULE17
      (sig_lost_q && !readapt_cmd) |=> sig_lost_q)
      else $error("signal loss flag dropped");
   a_lock_lost_hold: assert property (@(posedge clk) disable iff (rst) // RULE17
      (lock_lost_q && !readapt_cmd) |=> lock_lost_q)
      else $error("lock loss flag dropped");

   // Search start, candidate stepping, choice, freeze and restart
   a_search_start: assert property (@(posedge clk) disable iff (rst) // RULE4 RULE12
      s_idle_go |=> (adapt_busy && (cand_idx == '0)))
      else $error("search did not start on acquisition");
   a_cand_shown: assert property (@(posedge clk) disable iff (rst) // RULE8 RULE4
      (st_q == retimer_ctrl_pkg::ADAPT_SCORE) |=> (boost_code == $past(table_q[cand_idx])))
      else $error("candidate boost not applied");
   a_best_applied: assert property (@(posedge clk) disable iff (rst) // RULE19
      (st_q == retimer_ctrl_pkg::ADAPT_APPLY) |=> (boost_code == $past(table_q[best_idx])))
      else $error("best entry not applied");
   a_freeze_on_lock: assert property (@(posedge clk) disable iff (rst) // RULE5
      s_lock_seen |=> adapt_frozen)
      else $error("lock did not freeze boost");
   a_readapt_restart: assert property (@(posedge clk) disable iff (rst) // RULE20
      s_readapt_go |=> (adapt_busy && (cand_idx == '0)))
      else $error("re-adapt did not restart at entry zero");
   a_readapt_gate: assert property (@(posedge clk) disable iff (rst) // RULE20
      (readapt_cmd && !lk_s && !adapt_busy && (st_q != retimer_ctrl_pkg::ADAPT_IDLE)) |=> !adapt_busy)
      else $error("re-adapt taken while unlocked");
   a_cdr_reset_abort: assert property (@(posedge clk) disable iff (rst) // RULE6
      crs_s |=> (!adapt_frozen && !adapt_busy))
      else $error("clock recovery reset did not restart");
   a_level_sum: assert property (@(posedge clk) disable iff (rst) // RULE10
      (boost_code == 8'hFF) |-> (boost_level == 5'h0C))
      else $error("boost level sum wrong");
endmodule

/* dv/host_model.sv */
// Host controller model that issues channel register writes
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic       clk,
   // Register write port toward the channel
   output logic            reg_wr,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   // Idle values at time zero so the channel never sees an unknown strobe
   initial begin
      reg_wr    = 1'b0;
      reg_addr  = 8'hFF;
      reg_wdata = 8'h00;
   end

   // One byte per write, strobe held for exactly one clock, launched on the falling edge, clear of the sampling edge
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_addr  = ~addr; // Released bus shows no stale value
      reg_wdata = ~data;
   endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the channel control block
`timescale 1ns/1ps
module tb_top;
   logic       clk;
   logic       rst;
   logic       reg_wr;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       sig_detect;
   logic       cdr_locked;
   logic       cdr_reset;
   logic       score_valid;
   logic [7:0] score;
   logic       datapath_en;
   logic [7:0] boost_code;
   logic [4:0] boost_level;
   logic       stage4_limit;
   logic [2:0] swing;
   logic [3:0] deemph;
   logic       adapt_busy;
   logic       adapt_frozen;
   logic       int_o;
   logic       int_oe;
   logic       sig_lost_q;
   logic       lock_lost_q;
   int         miscompares;
   int         num_checks;
   logic [7:0] tbl [32];

   host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   retimer_channel_eq_adapt_ctrl i_dut (
      .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .sig_detect(sig_detect), .cdr_locked(cdr_locked), .cdr_reset(cdr_reset),
      .score_valid(score_valid), .adapt_merit_score(score), .datapath_en(datapath_en),
      .boost_code(boost_code), .boost_level(boost_level), .stage4_limit(stage4_limit),
      .output_swing_setting(swing), .deemph_setting(deemph), .adapt_busy(adapt_busy),
      .adapt_frozen(adapt_frozen), .int_o(int_o), .int_oe(int_oe),
      .sig_lost_q(sig_lost_q), .lock_lost_q(lock_lost_q));

   // Free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Counts, verdict and end of run, all in one place
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait for the search to start; a hang ends the run
   task automatic wait_busy();
      int n;
      for (n = 0; n < 50 && adapt_busy !== 1'b1; n++) @(negedge clk);
      if (adapt_busy !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: search never started", $time);
         give_verdict();
      end
   endtask

   // Scores every candidate in table order; best and its tied twin get the top score
   task automatic search(input int best, input int twin);
      int k;
      logic [7:0] e;
      wait_busy();
      for (k = 0; k < 32; k++) begin
         cycles(3);
         check(boost_code, tbl[k], "candidate");
         score       = (k == best || k == twin) ? 8'hF0 : 8'(k);
         score_valid = 1'b1;
         @(negedge clk);
         score_valid = 1'b0;
      end
      cycles(4);
      e = tbl[best];
      check(boost_code, e, "chosen boost");
      check(8'(boost_level), 8'(e[7:6]) + 8'(e[5:4]) + 8'(e[3:2]) + 8'(e[1:0]), "boost level");
   endtask

   initial begin
      miscompares = 0;
      num_checks  = 0;
      rst         = 1'b1;
      sig_detect  = 1'b0;
      cdr_locked  = 1'b0;
      cdr_reset   = 1'b0;
      score_valid = 1'b0;
      score       = 8'h00;
      for (int i = 0; i < 32; i++) tbl[i] = 8'(i * 7 + 3);
      tbl[31] = 8'hFF; // Full-boost entry reaches the top of the level sum
      cycles(12);
      rst = 1'b0;
      @(negedge clk);
      // Reset state: automatic mode, nothing powered, settings cleared
      check(8'(datapath_en), 8'h00, "path after reset");
      check(8'(adapt_frozen), 8'h00, "frozen after reset");
      check(8'(swing), 8'h00, "swing after reset");
      check(8'(int_oe), 8'h00, "irq after reset");
      $display("test reset done");
      // Driver settings, with an unmapped write that must leave them alone
      i_host.wr(8'h2D, 8'h07);
      i_host.wr(8'h15, 8'h0A);
      i_host.wr(8'h33, 8'hFF);
      @(negedge clk);
      check(8'(swing), 8'h07, "swing top code");
      check(8'(deemph), 8'h0A, "deemphasis");
      $display("test driver settings done");
      // Program the whole candidate table, one idle clock between writes
      for (int i = 0; i < 32; i++) i_host.wr(8'h40 + 8'(i), tbl[i]);
      sig_detect = 1'b1;
      cycles(5);
      check(8'(datapath_en), 8'h01, "path on detect");
      search(5, 9);
      // Re-adapt while still unlocked must be ignored
      i_host.wr(8'h14, 8'h04);
      @(negedge clk);
      check(8'(adapt_busy), 8'h00, "re-adapt refused unlocked");
      check(boost_code, tbl[5], "boost kept unlocked");
      cdr_locked = 1'b1;
      cycles(6);
      check(8'(adapt_frozen), 8'h01, "frozen on lock");
      score       = 8'hFF;
      score_valid = 1'b1;
      @(negedge clk);
      score_valid = 1'b0;
      cycles(3);
      check(boost_code, tbl[5], "boost held");
      $display("test first adaptation done");
      // Re-adapt while locked restarts from entry zero; best at the last index
      i_host.wr(8'h14, 8'h04);
      search(31, 31);
      cycles(6);
      check(8'(adapt_frozen), 8'h01, "frozen again");
      $display("test re-adapt done");
      // Lock loss raises the interrupt; clock-recovery reset restarts the search
      cdr_locked = 1'b0;
      cycles(6);
      check(8'(lock_lost_q), 8'h01, "lock lost flag");
      check(8'(int_oe), 8'h01, "irq driven");
      check(8'(int_o), 8'h00, "irq low");
      cdr_reset = 1'b1;
      cycles(6);
      check(8'(adapt_busy), 8'h00, "held in reset");
      cdr_reset = 1'b0;
      wait_busy();
      check(8'(adapt_busy), 8'h01, "search restarted");
      $display("test reacquire done");
      // Stage four limiting, then forced disable beating the detector
      i_host.wr(8'h14, 8'h02);
      @(negedge clk);
      check(8'(stage4_limit), 8'h01, "limiting stage");
      i_host.wr(8'h14, 8'h01);
      cycles(3);
      check(8'(datapath_en), 8'h00, "forced off");
      i_host.wr(8'h14, 8'h00);
      cycles(3);
      check(8'(datapath_en), 8'h01, "detector back");
      sig_detect = 1'b0;
      cycles(6);
      check(8'(datapath_en), 8'h00, "path off on loss");
      check(8'(sig_lost_q), 8'h01, "signal lost flag");
      check(8'(swing), 8'h07, "swing untouched");
      $display("test detect and force done");
      give_verdict();
   end
endmodule
